// File: common/cpm_pkg.sv
package cpm_pkg;

  localparam int AW = 6;

  // Register indices; the byte address is four times the index.
  localparam int IDX_CC0  = 6;
  localparam int IDX_CC1  = 7;
  localparam int IDX_WAKE = 9;
  localparam int IDX_OCD  = 12;
  localparam logic [AW-1:0] ADDR_CC0  = AW'(IDX_CC0 * 4);
  localparam logic [AW-1:0] ADDR_CC1  = AW'(IDX_CC1 * 4);
  localparam logic [AW-1:0] ADDR_WAKE = AW'(IDX_WAKE * 4);
  localparam logic [AW-1:0] ADDR_OCD  = AW'(IDX_OCD * 4);

  localparam logic [7:0] RST_CC0  = 8'h20;
  localparam logic [7:0] RST_CC1  = 8'h20;
  localparam logic [7:0] RST_WAKE = 8'h00;
  localparam logic [7:0] RST_OCD  = 8'h04;
  localparam logic [7:0] MASK_CC0  = 8'h6e;
  localparam logic [7:0] MASK_WAKE = 8'he1;
  localparam logic [7:0] MASK_OCD  = 8'h07;

  // Bit positions.
  localparam int B_WPS    = 1;
  localparam int B_XSTOP  = 5;
  localparam int B_DIV8   = 6;
  localparam int B_ACS    = 0;
  localparam int B_FBR    = 1;
  localparam int B_PINSW  = 3;
  localparam int B_LSSTOP = 4;
  localparam int B_DIVF   = 6;
  localparam int B_WAITC  = 0;
  localparam int B_EXDIV  = 5;
  localparam int B_WAKE   = 6;
  localparam int B_DET    = 0;
  localparam int B_DIRQ   = 1;
  localparam int B_ISEL   = 2;
  localparam int B_MON    = 3;

  localparam logic [1:0] WPS_RUN   = 2'b00;
  localparam logic [1:0] WAKE_XTAL = 2'b11;
  localparam logic [1:0] DIVF_1    = 2'b00;
  localparam logic [1:0] DIVF_2    = 2'b01;
  localparam logic [1:0] DIVF_4    = 2'b10;
  localparam logic [1:0] DET_BOTH  = 2'b11;

  // Divider terminal counts (ratio minus one).
  localparam logic [3:0] TC_DIV1  = 4'h0;
  localparam logic [3:0] TC_DIV2  = 4'h1;
  localparam logic [3:0] TC_DIV4  = 4'h3;
  localparam logic [3:0] TC_DIV8  = 4'h7;
  localparam logic [3:0] TC_DIV16 = 4'hf;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    PM_RUN  = 3'b001,
    PM_WAIT = 3'b010,
    PM_STOP = 3'b100
  } cpm_pm_t;

  function automatic logic [3:0] cpm_tc(input logic div8, input logic [1:0] field);
    if (div8) begin
      return TC_DIV8;
    end
    case (field)
      DIVF_1:  return TC_DIV1;
      DIVF_2:  return TC_DIV2;
      DIVF_4:  return TC_DIV4;
      default: return TC_DIV16;
    endcase
  endfunction

endpackage

// File: common/cpm_div_if.sv
`timescale 1ns/1ps
interface cpm_div_if;
  logic [3:0] tc;
  logic       run;
  logic       tick;
  modport ctrl (output tc, output run, input tick);
  modport div  (input tc, input run, output tick);
endinterface

// File: design/cpm_clkdiv.sv
`timescale 1ns/1ps
module cpm_clkdiv
  import cpm_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Divider control.
  cpm_div_if.div   dv
);

  logic [3:0] cnt;

  // One tick every tc plus one cycles while running.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt     <= 4'h0;
      dv.tick <= 1'b0;
    end else if (!dv.run) begin
      cnt     <= 4'h0;
      dv.tick <= 1'b0;
    end else if (cnt >= dv.tc) begin
      cnt     <= 4'h0;
      dv.tick <= 1'b1;
    end else begin
      cnt     <= cnt + 4'h1;
      dv.tick <= 1'b0;
    end
  end

  a_div_one_tick: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dv.run && dv.tc == TC_DIV1) |=> dv.tick)
    else $error("undivided clock missed a tick");

  a_div_two_gap: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dv.tick && dv.run && $stable(dv.tc) && dv.tc == TC_DIV2) |=> !dv.tick)
    else $error("divide-by-2 ticked twice in a row");

endmodule

// File: design/cpm_top.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module cpm_top
  import cpm_pkg::*;
(
  // Clock and reset.
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // AXI4-Lite slave.
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // System events.
  input  wire logic          write_unlock,
  input  wire logic          wait_instr,
  input  wire logic          periph_irq,
  input  wire logic          crystal_stopped,
  // Clock and power controls.
  output logic               cpu_clk_en,
  output logic               periph_clk_run,
  output logic               crystal_osc_en,
  output logic               lowspeed_osc_en,
  output logic               feedback_res_en,
  output logic               xtal_pin_osc,
  output logic               sysclk_internal,
  output logic               wait_mode,
  output logic               stop_mode,
  output logic               osc_stop_irq
);

  cpm_div_if dv ();

  logic [7:0]    cc0;
  logic [7:0]    cc1;
  logic [7:0]    wake;
  logic [7:0]    osc_stop_detect;
  logic          mon;
  cpm_pm_t       pm;
  cpm_pm_t       next_pm;
  logic          aw_have;
  logic          w_have;
  logic [AW-1:0] wr_addr;
  logic [7:0]    wd;
  logic          wr_lane0;
  logic          wr_go;
  logic          wr_ok;
  logic          next_aw_have;
  logic          next_w_have;
  logic          next_bvalid;
  logic          next_rvalid;
  logic          aw_fire;
  logic          w_fire;
  logic          ar_fire;
  logic          wr_cc0;
  logic          wr_cc1;
  logic          wr_wake;
  logic          wr_ocd;
  logic          exdiv_now;
  logic          enter_wait;
  logic          enter_stop;
  logic          exit_ev;
  logic          wake_xtal;
  logic          osc_fail;
  logic [7:0]    rd_byte;
  logic          rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  assign aw_fire      = s_axi_awvalid && s_axi_awready;
  assign w_fire       = s_axi_wvalid && s_axi_wready;
  assign ar_fire      = s_axi_arvalid && s_axi_arready;
  assign wr_go        = aw_have && w_have && !s_axi_bvalid;
  assign wr_ok        = wr_go && wr_lane0 && write_unlock;
  assign next_aw_have = (aw_have || aw_fire) && !wr_go;
  assign next_w_have  = (w_have || w_fire) && !wr_go;
  assign next_bvalid  = wr_go || (s_axi_bvalid && !s_axi_bready);
  assign next_rvalid  = ar_fire || (s_axi_rvalid && !s_axi_rready);
  assign wr_cc0       = wr_ok && wr_addr == ADDR_CC0;
  assign wr_cc1       = wr_ok && wr_addr == ADDR_CC1;
  assign wr_wake      = wr_ok && wr_addr == ADDR_WAKE;
  assign wr_ocd       = wr_ok && wr_addr == ADDR_OCD;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      wr_addr       <= '0;
      wd            <= 8'h00;
      wr_lane0      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_have       <= next_aw_have;
      w_have        <= next_w_have;
      s_axi_awready <= !next_aw_have && !next_bvalid;
      s_axi_wready  <= !next_w_have && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (aw_fire) begin
        wr_addr <= s_axi_awaddr;
      end
      if (w_fire) begin
        wd       <= s_axi_wdata[7:0];
        wr_lane0 <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_bresp <= (wr_addr == ADDR_CC0 || wr_addr == ADDR_CC1 || wr_addr == ADDR_WAKE ||
                        wr_addr == ADDR_OCD) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    unique case (s_axi_araddr)
      ADDR_CC0:  rd_byte = cc0;
      ADDR_CC1:  rd_byte = cc1;
      ADDR_WAKE: rd_byte = wake;
      ADDR_OCD:  rd_byte = {osc_stop_detect[7:B_MON+1], mon, osc_stop_detect[B_MON-1:0]};
      default:   rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_fire) begin
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode sequencing.

  assign exdiv_now  = wr_wake ? wd[B_EXDIV] : wake[B_EXDIV];
  assign enter_stop = pm == PM_RUN && wr_cc1 && wd[B_ACS];
  assign enter_wait = pm == PM_RUN && !enter_stop && (wait_instr || (wr_wake && wd[B_WAITC]));
  assign exit_ev    = pm != PM_RUN && periph_irq;
  assign wake_xtal  = exit_ev && wake[B_WAKE+1:B_WAKE] == WAKE_XTAL;
  assign osc_fail   = osc_stop_detect[B_DIRQ:B_DET] == DET_BOTH && crystal_stopped && !osc_stop_detect[B_ISEL];

  always_comb begin
    next_pm = pm;
    unique case (pm)
      PM_RUN: begin
        if (enter_stop) begin
          next_pm = PM_STOP;
        end else if (enter_wait) begin
          next_pm = PM_WAIT;
        end
      end
      PM_WAIT, PM_STOP: begin
        if (exit_ev) begin
          next_pm = PM_RUN;
        end
      end
      default: next_pm = PM_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pm <= PM_RUN;
    end else begin
      pm <= next_pm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cc0 <= RST_CC0;
    end else begin
      if (wr_cc0) begin
        cc0 <= wd & MASK_CC0;
      end
      if (enter_wait && exdiv_now) begin
        cc0[B_DIV8] <= 1'b0;
      end
      if (enter_stop) begin
        cc0[B_DIV8] <= 1'b1;
      end
      if (wake_xtal) begin
        cc0[B_XSTOP] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cc1 <= RST_CC1;
    end else begin
      if (wr_cc1) begin
        cc1           <= wd;
        cc1[B_PINSW]  <= wd[B_PINSW] || cc1[B_PINSW];
      end
      if (enter_wait && exdiv_now) begin
        cc1[B_DIVF+1:B_DIVF] <= DIVF_1;
      end
      if (exit_ev) begin
        cc1[B_ACS] <= 1'b0;
      end
      if (wake_xtal) begin
        cc1[B_PINSW] <= 1'b1;
      end
      if (osc_stop_detect[B_ISEL] || osc_fail) begin
        cc1[B_LSSTOP] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wake <= RST_WAKE;
    end else begin
      if (wr_wake) begin
        wake <= wd & MASK_WAKE;
      end
      if (exit_ev) begin
        wake[B_WAITC] <= 1'b0;
      end
    end
  end

  // A detected stop wins over a software write in the same cycle.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      osc_stop_detect <= RST_OCD;
    end else begin
      if (wr_ocd) begin
        osc_stop_detect          <= wd & MASK_OCD;
        osc_stop_detect[B_ISEL]  <= wd[B_ISEL] || mon;
      end
      if (wake_xtal) begin
        osc_stop_detect[B_ISEL] <= 1'b0;
      end
      if (osc_fail) begin
        osc_stop_detect[B_ISEL] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mon <= 1'b0;
    end else begin
      mon <= osc_stop_detect[B_DET] && crystal_stopped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU clock divider and clock outputs.

  assign dv.tc  = cpm_tc(cc0[B_DIV8], cc1[B_DIVF+1:B_DIVF]);
  assign dv.run = pm != PM_STOP;

  cpm_clkdiv u_div (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .dv      (dv)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_clk_en      <= 1'b0;
      periph_clk_run  <= 1'b1;
      crystal_osc_en  <= 1'b0;
      lowspeed_osc_en <= 1'b1;
      feedback_res_en <= 1'b1;
      xtal_pin_osc    <= 1'b0;
      sysclk_internal <= 1'b1;
      wait_mode       <= 1'b0;
      stop_mode       <= 1'b0;
      osc_stop_irq    <= 1'b0;
    end else begin
      cpu_clk_en      <= dv.tick && pm == PM_RUN;
      periph_clk_run  <= pm == PM_RUN || (pm == PM_WAIT && cc0[B_WPS+1:B_WPS] == WPS_RUN);
      crystal_osc_en  <= (!cc0[B_XSTOP] || !osc_stop_detect[B_ISEL]) && pm != PM_STOP;
      lowspeed_osc_en <= !cc1[B_LSSTOP] && pm != PM_STOP;
      feedback_res_en <= !cc1[B_FBR] && !cc1[B_ACS];
      xtal_pin_osc    <= cc1[B_PINSW];
      sysclk_internal <= osc_stop_detect[B_ISEL];
      wait_mode       <= pm == PM_WAIT;
      stop_mode       <= pm == PM_STOP;
      osc_stop_irq    <= osc_fail;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_stop_div8: assert property (enter_stop |=> cc0[B_DIV8] && pm == PM_STOP)
    else $error("stop entry did not force divide-by-8");
  a_wait_bit_clear: assert property (exit_ev |=> !wake[B_WAITC] && pm == PM_RUN)
    else $error("wake did not clear wait control");
  a_pin_sticky: assert property (cc1[B_PINSW] |=> cc1[B_PINSW])
    else $error("pin switch returned to port");
  a_lsstop_held: assert property (osc_stop_detect[B_ISEL] |=> !cc1[B_LSSTOP])
    else $error("low-speed stop set while internal selected");
  a_monitor_off: assert property (!osc_stop_detect[B_DET] |=> !mon)
    else $error("monitor set with detection off");
  a_auto_select: assert property (osc_fail |=> osc_stop_detect[B_ISEL] && osc_stop_irq ##1 sysclk_internal)
    else $error("stop detection did not select internal clock");
  a_wait_cpu_off: assert property (pm != PM_RUN |=> !cpu_clk_en)
    else $error("cpu clock ran in wait or stop");
  a_periph_gate: assert property ((pm == PM_WAIT && cc0[B_WPS+1:B_WPS] != WPS_RUN) |=> !periph_clk_run)
    else $error("peripheral clock ran in gated wait");
  a_wake_xtal: assert property ((wake_xtal && !osc_fail) |=> !osc_stop_detect[B_ISEL] && cc1[B_PINSW] && !cc0[B_XSTOP])
    else $error("crystal wake did not restore crystal");
  a_exit_div: assert property ((enter_wait && exdiv_now) |=> !cc0[B_DIV8] && cc1[B_DIVF+1:B_DIVF] == DIVF_1)
    else $error("wait entry did not select undivided clock");
  a_fbr_cut: assert property (cc1[B_ACS] |=> !feedback_res_en)
    else $error("feedback resistor on in stop");
  a_locked_write: assert property ((wr_go && !write_unlock && wr_addr == ADDR_OCD && !osc_fail && !wake_xtal)
    |=> $stable(osc_stop_detect))
    else $error("locked write changed detection register");

  c_wait: cover property (enter_wait ##[1:50] exit_ev);
  c_stop: cover property (enter_stop ##[1:50] wake_xtal);
  c_fail: cover property (osc_fail);

endmodule

// File: tb/cpm_xtal_model.sv
`timescale 1ns/1ps
module cpm_xtal_model (
  // Oscillator control from the block.
  input  wire logic crystal_osc_en,
  // Bench command that breaks the crystal.
  input  wire logic fail,
  // Detector output.
  output logic      crystal_stopped
);
  // The crystal only oscillates while enabled and not broken.
  assign crystal_stopped = !crystal_osc_en || fail;
endmodule

// File: tb/test_cpm_top.sv
`timescale 1ns/1ps
module test_cpm_top;
  import cpm_pkg::*;
  logic          sys_clk, rstn;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0]   wdata, rdata;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp;
  logic          awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid;
  logic          unlock, wait_instr, periph_irq, xstopped, xfail;
  logic          cpu_clk_en, periph_run, xosc_en, ls_en, fb_en;
  logic          pin_osc, sys_int, wait_mode, stop_mode, osc_irq;
  int            err_count, total_checks;

  always #25 sys_clk = ~sys_clk;

  cpm_top dut (
    .sys_clk(sys_clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .write_unlock(unlock), .wait_instr(wait_instr), .periph_irq(periph_irq),
    .crystal_stopped(xstopped), .cpu_clk_en(cpu_clk_en), .periph_clk_run(periph_run),
    .crystal_osc_en(xosc_en), .lowspeed_osc_en(ls_en), .feedback_res_en(fb_en),
    .xtal_pin_osc(pin_osc), .sysclk_internal(sys_int), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .osc_stop_irq(osc_irq)
  );

  cpm_xtal_model xtal (.crystal_osc_en(xosc_en), .fail(xfail), .crystal_stopped(xstopped));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    err_count++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    @(posedge sys_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h0, d};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        chk(bresp, er);
        break;
      end
    end
    if (k == 50) timeout();
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp, input logic [1:0] er);
    int k;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        chk(rdata, exp);
        chk(rresp, er);
        break;
      end
    end
    if (k == 50) timeout();
  endtask

  // Measures the spacing of CPU clock enables after two settling periods.
  task automatic period(input int exp);
    int k, n;
    for (k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (cpu_clk_en !== 1'b1 && n < 40);
    end
    chk(n, exp);
  endtask

  task automatic irq_pulse();
    @(posedge sys_clk);
    periph_irq <= 1'b1;
    @(posedge sys_clk);
    periph_irq <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(ADDR_CC0, 32'h20, RESP_OKAY);
    rd(ADDR_CC1, 32'h20, RESP_OKAY);
    rd(ADDR_WAKE, 32'h00, RESP_OKAY);
    rd(ADDR_OCD, 32'h04, RESP_OKAY);
    rd(6'h3c, 32'h0, RESP_SLVERR);
    wr(6'h00, 8'hff, RESP_SLVERR);
    chk({sys_int, ls_en, fb_en, pin_osc, wait_mode, stop_mode}, 6'b111000);
    $display("done reset");
  endtask

  task automatic t_protect();
    @(posedge sys_clk);
    unlock <= 1'b0;
    wr(ADDR_CC0, 8'h40, RESP_OKAY);
    rd(ADDR_CC0, 32'h20, RESP_OKAY);
    wr(ADDR_OCD, 8'h03, RESP_OKAY);
    rd(ADDR_OCD, 32'h04, RESP_OKAY);
    unlock <= 1'b1;
    wstrb  <= 4'he;
    wr(ADDR_CC0, 8'h40, RESP_OKAY);
    rd(ADDR_CC0, 32'h20, RESP_OKAY);
    wstrb  <= 4'hf;
    $display("done protect");
  endtask

  task automatic t_divider();
    int ex[4] = '{1, 2, 4, 16};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CC1, {2'(i), 6'h20}, RESP_OKAY);
      period(ex[i]);
    end
    wr(ADDR_CC0, 8'h60, RESP_OKAY);
    period(8);
    wr(ADDR_CC0, 8'h20, RESP_OKAY);
    wr(ADDR_CC1, 8'h20, RESP_OKAY);
    $display("done divider");
  endtask

  task automatic t_bits();
    wr(ADDR_CC1, 8'h30, RESP_OKAY);
    rd(ADDR_CC1, 32'h20, RESP_OKAY);
    wr(ADDR_CC1, 8'h28, RESP_OKAY);
    wr(ADDR_CC1, 8'h20, RESP_OKAY);
    rd(ADDR_CC1, 32'h28, RESP_OKAY);
    chk(pin_osc, 1'b1);
    wr(ADDR_CC1, 8'h2a, RESP_OKAY);
    rd(ADDR_CC1, 32'h2a, RESP_OKAY);
    chk(fb_en, 1'b0);
    wr(ADDR_CC1, 8'h28, RESP_OKAY);
    $display("done bits");
  endtask

  task automatic t_regwait();
    wr(ADDR_CC0, 8'h42, RESP_OKAY);
    wr(ADDR_CC1, 8'he8, RESP_OKAY);
    wr(ADDR_WAKE, 8'h21, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk({wait_mode, periph_run, cpu_clk_en}, 3'b100);
    rd(ADDR_CC0, 32'h02, RESP_OKAY);
    rd(ADDR_CC1, 32'h28, RESP_OKAY);
    rd(ADDR_WAKE, 32'h21, RESP_OKAY);
    irq_pulse();
    chk(wait_mode, 1'b0);
    rd(ADDR_WAKE, 32'h20, RESP_OKAY);
    period(1);
    wr(ADDR_WAKE, 8'h00, RESP_OKAY);
    wr(ADDR_CC0, 8'h20, RESP_OKAY);
    $display("done regwait");
  endtask

  task automatic t_stop();
    chk(fb_en, 1'b1);
    wr(ADDR_CC1, 8'h29, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk({stop_mode, fb_en, xosc_en, ls_en, periph_run, cpu_clk_en}, 6'b100000);
    rd(ADDR_CC0, 32'h60, RESP_OKAY);
    irq_pulse();
    chk({stop_mode, fb_en}, 2'b01);
    rd(ADDR_CC1, 32'h28, RESP_OKAY);
    $display("done stop");
  endtask

  task automatic t_wake();
    wr(ADDR_CC0, 8'h00, RESP_OKAY);
    wr(ADDR_WAKE, 8'hc0, RESP_OKAY);
    @(posedge sys_clk);
    wait_instr <= 1'b1;
    @(posedge sys_clk);
    wait_instr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({wait_mode, periph_run}, 2'b11);
    irq_pulse();
    chk({sys_int, pin_osc, xosc_en, wait_mode}, 4'b0110);
    rd(ADDR_OCD, 32'h00, RESP_OKAY);
    $display("done wake");
  endtask

  task automatic t_detect();
    int k;
    wr(ADDR_OCD, 8'h03, RESP_OKAY);
    rd(ADDR_OCD, 32'h03, RESP_OKAY);
    @(posedge sys_clk);
    xfail <= 1'b1;
    for (k = 0; k < 10; k++) begin
      @(posedge sys_clk);
      if (osc_irq === 1'b1) break;
    end
    chk(osc_irq, 1'b1);
    repeat (2) @(posedge sys_clk);
    chk({sys_int, ls_en}, 2'b11);
    rd(ADDR_OCD, 32'h0f, RESP_OKAY);
    wr(ADDR_OCD, 8'h03, RESP_OKAY);
    rd(ADDR_OCD, 32'h0f, RESP_OKAY);
    wr(ADDR_OCD, 8'h04, RESP_OKAY);
    rd(ADDR_OCD, 32'h04, RESP_OKAY);
    xfail <= 1'b0;
    $display("done detect");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {wait_instr, periph_irq, xfail} = '0;
    unlock = 1'b1;
    wstrb = 4'hf;
    err_count = 0;
    total_checks = 0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_protect();
    t_divider();
    t_bits();
    t_regwait();
    t_stop();
    t_wake();
    t_detect();
    stop_test();
  end
endmodule
